/* File: hdl/abu_pkg.sv */
/*
 * abu_pkg: shared constants and carrier types of the address breakpoint
 * unit. Assumes a 32-bit AXI4-Lite register bus and a 16-bit core bus.
 */
package abu_pkg;
  // word offsets of the registers on the axi4-lite slave
  localparam logic [15:0] ADDR_TARGET_HIGH  = 16'hFE0C;
  localparam logic [15:0] ADDR_TARGET_LOW   = 16'hFE0D;
  localparam logic [15:0] ADDR_STATUS_CTRL  = 16'hFE0E;
  // byte addresses used by the decoder: four times the word offsets above
  localparam logic [17:0] BYTE_TARGET_HIGH  = 18'h3F830;
  localparam logic [17:0] BYTE_TARGET_LOW   = 18'h3F834;
  localparam logic [17:0] BYTE_STATUS_CTRL  = 18'h3F838;
  localparam logic [17:0] BYTE_FLAG_CTRL    = 18'h3F83C;
  localparam logic [17:0] BYTE_IRQ_STATUS   = 18'h3F840;
  localparam logic [17:0] BYTE_IRQ_CLEAR    = 18'h3F844;
  localparam logic [17:0] BYTE_IRQ_ENABLE   = 18'h3F848;
  localparam logic [17:0] BYTE_SYS_STATUS   = 18'h3F84C;
  // field positions
  localparam int          POS_MATCH_EN      = 7;
  localparam int          POS_ACTIVE        = 6;
  localparam int          POS_FLAG_CLR      = 7;
  // reset values
  localparam logic [7:0]  RST_BYTE          = 8'h00;
  // break vectors, user and monitor mode
  localparam logic [15:0] VEC_USER          = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR       = 16'hFEFC;
  // interrupt event bits
  localparam int          EV_MATCH          = 0;
  localparam int          EV_SOFT           = 1;
  localparam int          EV_RETURN         = 2;
  localparam int          EV_WIDTH          = 3;
  // axi responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // core-side view sampled every cycle
  typedef struct packed {
    logic [15:0] addr;       // internal address bus
    logic        fromPc;     // address comes from the program counter
    logic        lastCycle;  // final cycle of the executing instruction
    logic        trapReturn; // trap_return_instruction retiring
    logic        waitMode;
    logic        stopMode;
    logic        monitorMode;
    logic        highTestVoltage;
  } abu_core_s;

  typedef enum logic [1:0] {BRK_IDLE, BRK_PENDING, BRK_ACTIVE} abu_state_e;
endpackage

/* File: hdl/abu_top.sv */
/*
 * abu_top: address breakpoint unit with axi4-lite registers.
 * Assumes the core presents its bus state synchronously to clk and acts on
 * brkRequest by forcing the soft trap instruction with brkVector.
 * Assumes the timer, watchdog and peripheral flag logic sit outside and
 * obey timerStop, watchdogOff and flagClearPermit as plain levels.
 * Assumes clkEn is the only gating: low freezes every register here, so
 * the core must not expect a break to start while it is low.
 */
// Our own choice: the AXI4-Lite slave port.
//
// Overview of operation
// [R1] raise break request on full address match
// [R2] core forces soft trap, vector by mode
// [R3] break waits for current instruction end
// [R4] trap return inside break ends break
// [R5] match enable bit 7, reset clears
// [R6] active bit set on match, cleared
// [R7] writing active bit one forces break
// [R8] break routine software clears active bit
// [R9] target address bytes, reset to zero
// [R10] timer counter stopped during break
// [R11] watchdog off in break with high voltage
// [R12] flag clear permit gates peripheral clears
// [R13] works in wait, wait exit indicator
// [R14] inactive in stop, registers kept
// [R15] only program counter addresses match
// [R16] match needs enable and both bytes equal
`timescale 1ns/1ps
module abu_top #(
  parameter int ADDR_W = 18  // axi address width in use
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire abu_pkg::abu_core_s core,
  output logic                   brkRequest,
  output logic [15:0]            brkVector,
  output logic                   timerStop,
  output logic                   watchdogOff,
  output logic                   flagClearPermit,
  output logic                   waitExitIndicator,
  output logic                   irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // the decoder reads bits 17:0, so a narrower bus cannot reach the map
  if (ADDR_W < 18) begin : gAddrCheck
    $error("abu_top: ADDR_W must be at least 18");
  end

  // register state; every bit here is cleared by rst and frozen by clkEn
  // the active bit and the break state are kept apart on purpose: software
  // owns the bit, while the core's trap return owns the state
  logic [7:0]                 targetHigh_q;  // target_addr_high
  logic [7:0]                 targetLow_q;   // target_addr_low
  logic                       matchEn_q;     // match_enable_bit
  logic                       active_q;      // break_active_bit
  logic                       flagClr_q;     // flag_clear_permit
  logic [abu_pkg::EV_WIDTH-1:0] irqStat_q;   // sticky events
  logic [abu_pkg::EV_WIDTH-1:0] irqEn_q;     // event enables
  abu_pkg::abu_state_e        state_q;
  logic                       waitExit_q;

  // write channel latches
  // each half is parked until its partner arrives, so the master may
  // offer address and data in either order
  logic [ADDR_W-1:0]          awAddr_q;
  logic                       awHeld_q;
  logic [31:0]                wData_q;
  logic [3:0]                 wStrb_q;
  logic                       wHeld_q;

  // address decode, shared by reads and writes
  // misaligned or unmapped addresses decode to 4'hF and answer SLVERR;
  // 4'hF is kept free so no register can alias it
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [17:0] b;
    b = a[17:0];
    if (a[1:0] != 2'h0) decode = 4'hF;
    else if (b == abu_pkg::BYTE_TARGET_HIGH) decode = 4'h0;
    else if (b == abu_pkg::BYTE_TARGET_LOW)  decode = 4'h1;
    else if (b == abu_pkg::BYTE_STATUS_CTRL) decode = 4'h2;
    else if (b == abu_pkg::BYTE_FLAG_CTRL)   decode = 4'h3;
    else if (b == abu_pkg::BYTE_IRQ_STATUS)  decode = 4'h4;
    else if (b == abu_pkg::BYTE_IRQ_CLEAR)   decode = 4'h5;
    else if (b == abu_pkg::BYTE_IRQ_ENABLE)  decode = 4'h6;
    else if (b == abu_pkg::BYTE_SYS_STATUS)  decode = 4'h7;
    else decode = 4'hF;
  endfunction

  // a write happens once both halves are latched and no response is open
  logic       doWrite;
  logic [3:0] wSel;
  logic       wLane0;
  logic [7:0] wByte;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wSel    = decode(awAddr_q);
  assign wLane0  = doWrite && wStrb_q[0];
  assign wByte   = wData_q[7:0];

  // core-side conditions; stop mode freezes the comparator entirely
  // only program counter fetches may match, so data accesses to the
  // target address never start a break
  logic addrMatch;
  logic softSet;
  logic activeClr;
  logic stopped;
  assign stopped   = core.stopMode;                              // [R14]
  assign addrMatch = !stopped && matchEn_q && core.fromPc        // [R15]
                     && core.addr[15:8] == targetHigh_q          // [R16]
                     && core.addr[7:0] == targetLow_q;           // [R1]
  assign softSet   = wLane0 && wSel == 4'h2
                     && wByte[abu_pkg::POS_ACTIVE];              // [R7]
  assign activeClr = wLane0 && wSel == 4'h2
                     && !wByte[abu_pkg::POS_ACTIVE];             // [R8]

  // axi write address and data acceptance, either order
  // a handshake always wins over the drop on doWrite; the readies are
  // low while a half is held, so the two never meet
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // ready outputs registered; each drops once its half is held
  // the ready falls in the cycle after its own handshake, trading one
  // idle cycle per write for a flop-driven ready
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clkEn) begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
    end
  end

  // write response, one cycle after both halves meet
  // interrupt status and system status are read-only to stores and answer SLVERR;
  // the system status store still clears the wait exit flag
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= abu_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wSel == 4'hF || wSel == 4'h4 || wSel == 4'h7)
                        ? abu_pkg::RESP_SLVERR : abu_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // target address bytes; untouched by stop mode
  // only byte lane 0 stores; the upper lanes of a word are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      targetHigh_q <= abu_pkg::RST_BYTE;                         // [R9]
      targetLow_q  <= abu_pkg::RST_BYTE;                         // [R9]
    end else if (clkEn && wLane0) begin
      if (wSel == 4'h0) targetHigh_q <= wByte;
      if (wSel == 4'h1) targetLow_q  <= wByte;
    end
  end

  // control bits: match enable and flag clear permit
  // the permit only reaches its pin while a break is active
  always_ff @(posedge clk) begin
    if (rst) begin
      matchEn_q <= 1'b0;                                         // [R5]
      flagClr_q <= 1'b0;
    end else if (clkEn && wLane0) begin
      if (wSel == 4'h2) matchEn_q <= wByte[abu_pkg::POS_MATCH_EN]; // [R5]
      if (wSel == 4'h3) flagClr_q <= wByte[abu_pkg::POS_FLAG_CLR]; // [R12]
    end
  end

  // break active bit: a match wins over a simultaneous software clear
  // a clear lost this way is harmless: the match that beat it is a new
  // break event, which the routine must see
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
    end else if (clkEn) begin
      if (addrMatch || softSet) active_q <= 1'b1;                // [R6]
      else if (activeClr) active_q <= 1'b0;                      // [R6]
    end
  end

  // break sequencer: a match waits for the instruction boundary
  // a pending match cannot be withdrawn; it fires at the next boundary
  // even if the enable is dropped meanwhile
  // stop mode holds the state as it stands
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= abu_pkg::BRK_IDLE;
    end else if (clkEn && !stopped) begin
      unique case (state_q)
        abu_pkg::BRK_IDLE: begin
          // software request or match on last cycle starts at once [R3]
          if (softSet || (addrMatch && core.lastCycle))
            state_q <= abu_pkg::BRK_ACTIVE;
          else if (addrMatch)
            state_q <= abu_pkg::BRK_PENDING;                     // [R3]
        end
        abu_pkg::BRK_PENDING: begin
          if (core.lastCycle) state_q <= abu_pkg::BRK_ACTIVE;    // [R3]
        end
        abu_pkg::BRK_ACTIVE: begin
          if (core.trapReturn) state_q <= abu_pkg::BRK_IDLE;     // [R4]
        end
      endcase
    end
  end

  // request and side effects toward the core and peripherals
  // brkRequest is the sequencer's entry to active, and also fires on a software
  // request while pending, so a break that was pending can pulse it twice
  always_ff @(posedge clk) begin
    if (rst) begin
      brkRequest      <= 1'b0;
      brkVector       <= abu_pkg::VEC_USER;
      timerStop       <= 1'b0;
      watchdogOff     <= 1'b0;
      flagClearPermit <= 1'b0;
    end else if (clkEn) begin
      // one pulse as the break begins; core forces the soft trap [R2]
      brkRequest  <= !stopped && state_q != abu_pkg::BRK_ACTIVE
                     && (softSet || (addrMatch && core.lastCycle)
                     || (state_q == abu_pkg::BRK_PENDING
                         && core.lastCycle));                    // [R1]
      brkVector   <= core.monitorMode ? abu_pkg::VEC_MONITOR
                                      : abu_pkg::VEC_USER;       // [R2]
      timerStop   <= state_q == abu_pkg::BRK_ACTIVE;             // [R10]
      watchdogOff <= state_q == abu_pkg::BRK_ACTIVE
                     && core.highTestVoltage;                    // [R11]
      flagClearPermit <= state_q == abu_pkg::BRK_ACTIVE
                         && flagClr_q;                           // [R12]
    end
  end

  // wait exit indicator: set when a break begins in wait mode
  // it is sticky until software stores to the system status word, so a
  // later exit from wait by another source cannot hide it
  always_ff @(posedge clk) begin
    if (rst) begin
      waitExit_q        <= 1'b0;
      waitExitIndicator <= 1'b0;
    end else if (clkEn) begin
      if (core.waitMode && brkRequest) waitExit_q <= 1'b1;       // [R13]
      else if (wLane0 && wSel == 4'h7) waitExit_q <= 1'b0;
      waitExitIndicator <= waitExit_q;                           // [R13]
    end
  end

  // sticky interrupt status; new events beat a same-cycle clear
  // irq lags the status by one cycle, the price of a flop-driven output
  logic [abu_pkg::EV_WIDTH-1:0] events;
  logic [abu_pkg::EV_WIDTH-1:0] clrMask;
  assign events  = {state_q == abu_pkg::BRK_ACTIVE && core.trapReturn,
                    softSet, addrMatch};
  assign clrMask = (wLane0 && wSel == 4'h5)
                   ? wByte[abu_pkg::EV_WIDTH-1:0] : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= '0;
      irqEn_q   <= '0;
      irq       <= 1'b0;
    end else if (clkEn) begin
      irqStat_q <= (irqStat_q & ~clrMask) | events;
      if (wLane0 && wSel == 4'h6) irqEn_q <= wByte[abu_pkg::EV_WIDTH-1:0];
      irq <= |(irqStat_q & irqEn_q);
    end
  end

  // read channel: data one cycle after the address is taken
  // the address is decoded straight from the bus, so araddr must stand
  // while arvalid is high, as the protocol already demands
  logic [7:0] rByte;
  logic [3:0] rSel;
  always_comb begin
    rSel  = decode(s_axi_araddr);
    rByte = 8'h00;
    unique case (rSel)
      4'h0: rByte = targetHigh_q;
      4'h1: rByte = targetLow_q;
      4'h2: rByte = {matchEn_q, active_q, 6'h00};                // [R6]
      4'h3: rByte = {flagClr_q, 7'h00};
      4'h4: rByte = {5'h00, irqStat_q};
      4'h6: rByte = {5'h00, irqEn_q};
      4'h7: rByte = {7'h00, waitExit_q};
      default: rByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= abu_pkg::RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rByte};
        s_axi_rresp  <= (rSel == 4'hF || rSel == 4'h5)
                        ? abu_pkg::RESP_SLVERR : abu_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/abu_core_model.sv */
/* core model: the processor side of the breakpoint unit.
   assumes the bench supplies the fetch stream and the mode levels */
`timescale 1ns/1ps
module abu_core_model (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          brkRequest,
  input  wire logic [3:0]    retDly,
  input  wire logic [15:0]   pcIn,
  input  wire logic [5:0]    modeIn,
  output abu_pkg::abu_core_s core
);
  logic [3:0] retCnt_q; // cycles left in the break routine
  logic       ret_q;    // trap return retiring this cycle

  // break routine length is set by the bench, so prompt and slow
  // returns can both be tried
  always_ff @(posedge clk) begin
    ret_q <= 1'b0;
    if (rst) begin
      retCnt_q <= 4'h0;
    end else if (brkRequest) begin
      retCnt_q <= retDly; // soft trap forced, routine starts
    end else if (retCnt_q != 4'h0) begin
      retCnt_q <= retCnt_q - 4'h1;
      ret_q    <= (retCnt_q == 4'h1); // routine ends in a return
    end
  end

  // bits of modeIn: last, fromPc, wait, stop, monitor, high voltage
  assign core = '{addr: pcIn, fromPc: modeIn[4], lastCycle: modeIn[5],
    trapReturn: ret_q, waitMode: modeIn[3], stopMode: modeIn[2],
    monitorMode: modeIn[1], highTestVoltage: modeIn[0]};
endmodule

/* File: tb/abu_top_asserts.sv */
/* checker: timing relations at the breakpoint unit's ports.
   assumes clkEn is dropped only while the unit is idle */
`timescale 1ns/1ps
module abu_top_asserts (
  input wire logic               clk,
  input wire logic               rst,
  input wire abu_pkg::abu_core_s core,
  input wire logic               brkRequest,
  input wire logic [15:0]        brkVector,
  input wire logic               timerStop,
  input wire logic               watchdogOff,
  input wire logic               flagClearPermit,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  req_pulse_a: assert property (brkRequest |=> !brkRequest)
    else $error("break request held past one cycle");
  vec_monitor_a: assert property (brkRequest && $past(core.monitorMode)
    |-> brkVector == abu_pkg::VEC_MONITOR) else $error("bad monitor vector");
  vec_user_a: assert property (brkRequest && !$past(core.monitorMode)
    |-> brkVector == abu_pkg::VEC_USER) else $error("bad user vector");
  timer_stop_a: assert property (brkRequest |=> timerStop)
    else $error("timer kept running in break");
  break_end_a: assert property (timerStop && core.trapReturn
    |-> ##[1:2] !timerStop) else $error("break outlived trap return");
  wdog_in_break_a: assert property (watchdogOff |-> timerStop)
    else $error("watchdog off outside break");
  wdog_voltage_a: assert property (timerStop && core.highTestVoltage
    && $past(core.highTestVoltage) |-> watchdogOff)
    else $error("watchdog left on in break");
  permit_gate_a: assert property (flagClearPermit |-> timerStop)
    else $error("flag clear permitted outside break");
  stop_freeze_a: assert property (core.stopMode
    |=> $stable(brkRequest) && $stable(timerStop))
    else $error("unit moved in stop mode");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");

  cover property (brkRequest && $past(core.monitorMode));
  cover property (watchdogOff);
  cover property (flagClearPermit);
endmodule

bind abu_top abu_top_asserts abu_top_asserts_inst (.*);

/* File: tb/test_address_breakpoint_unit.sv */
/* bench for the address breakpoint unit: registers over the axi4-lite
   slave, fetch stream through the core model; assumes the package */
`timescale 1ns/1ps
module test_address_breakpoint_unit;
  localparam logic [5:0] LAST = 6'h20; // final cycle of an instruction
  localparam logic [5:0] PC   = 6'h10; // address from program counter
  localparam logic [5:0] WT   = 6'h08; // wait mode
  localparam logic [5:0] STP  = 6'h04; // stop mode
  localparam logic [5:0] MON  = 6'h02; // monitor mode
  localparam logic [5:0] HV   = 6'h01; // high test voltage
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               clkEn = 1'b1;  // dropped once while idle
  logic [15:0]        pcIn = 16'h0100; // idle fetch, never a target
  logic [5:0]         modeIn = 6'h00;
  logic [3:0]         retDly = 4'hF; // slow routine first
  logic [17:0]        s_axi_awaddr = 18'h00000;
  logic [17:0]        s_axi_araddr = 18'h00000;
  logic [31:0]        s_axi_wdata = 32'h00000000;
  logic [3:0]         s_axi_wstrb = 4'h1;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata;
  logic               brkRequest, timerStop, watchdogOff, irq;
  logic               flagClearPermit, waitExitIndicator;
  logic [15:0]        brkVector;
  abu_pkg::abu_core_s core;
  int                 mismatches = 0;
  int                 cmp_count = 0;
  int                 reqCnt = 0; // break requests seen
  int                 r0;
  logic [1:0]         wrResp;      // response of the last write
  logic [15:0]        missA [3] = '{16'h1234, 16'h1235, 16'h1334};
  logic [5:0]         missM [3] = '{LAST, PC | LAST, PC | LAST};

  abu_top abu_top_inst (.*);
  abu_core_model abu_core_model_inst (.*);

  always #2 clk = ~clk;
  always @(posedge clk) if (brkRequest === 1'b1) reqCnt++;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // a wait that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 64) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // register i sits at the first byte address plus four per index
  task automatic wr(input int i, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    s_axi_awaddr  <= abu_pkg::BYTE_TARGET_HIGH + 18'(i * 4);
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    s_axi_bready <= 1'b0;
    wrResp = s_axi_bresp;
    tmo(n);
  endtask

  task automatic rd(input int i, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    s_axi_araddr  <= abu_pkg::BYTE_TARGET_HIGH + 18'(i * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // hold a fetch for k cycles, then idle keeping the mode levels
  task automatic fetch(input logic [15:0] a, input logic [5:0] m, input int k);
    @(posedge clk);
    pcIn   <= a;
    modeIn <= m;
    cyc(k);
    pcIn   <= 16'h0100;
    modeIn <= m & 6'h0F;
  endtask

  initial begin
    cyc(16);
    rst <= 1'b0;
    rd(0, 32'h0, abu_pkg::RESP_OKAY);
    rd(2, 32'h0, abu_pkg::RESP_OKAY);
    rd(8, 32'h0, abu_pkg::RESP_SLVERR);
    wr(0, 8'h12);
    chk({30'h0, wrResp}, {30'h0, abu_pkg::RESP_OKAY});
    wr(1, 8'h34);
    rd(1, 32'h34, abu_pkg::RESP_OKAY);
    wr(6, 8'h07);
    r0 = reqCnt;
    fetch(16'h1234, PC | LAST, 3);
    cyc(3);
    chk(reqCnt - r0, 0);
    wr(2, 8'h80);
    foreach (missA[i]) begin
      fetch(missA[i], missM[i], 3);
      cyc(3);
      chk(reqCnt - r0, 0);
    end
    $display("test refusals done");
    fetch(16'h1234, PC, 4);
    cyc(3);
    chk(reqCnt - r0, 0);
    fetch(16'h0100, LAST, 1);
    cyc(3);
    chk(reqCnt - r0, 1);
    chk(timerStop, 1);
    chk(brkVector, abu_pkg::VEC_USER);
    rd(2, 32'hC0, abu_pkg::RESP_OKAY);
    rd(4, 32'h01, abu_pkg::RESP_OKAY);
    chk(irq, 1);
    cyc(24);
    chk(timerStop, 0);
    wr(5, 8'h07);
    wr(4, 8'h07);
    chk({30'h0, wrResp}, {30'h0, abu_pkg::RESP_SLVERR});
    rd(4, 32'h0, abu_pkg::RESP_OKAY);
    chk(irq, 0);
    wr(2, 8'h80);
    rd(2, 32'h80, abu_pkg::RESP_OKAY);
    $display("test match break done");
    wr(3, 8'h80);
    fetch(16'h0100, WT | MON | HV, 1);
    r0 = reqCnt;
    wr(2, 8'hC0);
    cyc(3);
    chk(reqCnt - r0, 1);
    chk(brkVector, abu_pkg::VEC_MONITOR);
    chk(watchdogOff, 1);
    chk(flagClearPermit, 1);
    rd(4, 32'h02, abu_pkg::RESP_OKAY);
    cyc(24);
    chk(waitExitIndicator, 1);
    rd(7, 32'h01, abu_pkg::RESP_OKAY);
    wr(6, 8'h00);
    cyc(2);
    chk(irq, 0);
    wr(5, 8'h07);
    wr(6, 8'h07);
    wr(2, 8'h80);
    fetch(16'h0100, 6'h00, 1);
    $display("test soft break done");
    fetch(16'h0100, STP, 1);
    r0 = reqCnt;
    fetch(16'h1234, STP | PC | LAST, 3);
    fetch(16'h0100, 6'h00, 3);
    chk(reqCnt - r0, 0);
    rd(0, 32'h12, abu_pkg::RESP_OKAY);
    rd(2, 32'h80, abu_pkg::RESP_OKAY);
    retDly <= 4'h2;
    fetch(16'h1234, PC | LAST, 1);
    cyc(3);
    chk(reqCnt - r0, 1);
    cyc(6);
    chk(timerStop, 0);
    clkEn <= 1'b0;
    fetch(16'h1234, PC | LAST, 2);
    chk(reqCnt - r0, 1);
    clkEn <= 1'b1;
    cyc(3);
    chk(reqCnt - r0, 1);
    $display("test stop and prompt return done");
    complete_run();
  end
endmodule
